// ==== logic/frd_defs.svh ====
`ifndef FRD_DEFS_SVH
`define FRD_DEFS_SVH

`define FRD_RECORDS       5
`define FRD_PHASES        3
`define FRD_RMS_W         16
`define FRD_ITEM_NEWEST   211
`define FRD_ITEM_OLDEST   215
`define FRD_SAMPLE_DEG    30
`define FRD_SPC           (360 / `FRD_SAMPLE_DEG)
`define FRD_CAP_CYC       224
`define FRD_CAP_PTS       (`FRD_CAP_CYC * `FRD_SPC)
`define FRD_PRE_RST       9'h070
`define FRD_POST_RST      9'h070

`define FRD_A_CTRL        8'h00
`define FRD_A_WIN         8'h04
`define FRD_A_STATUS      8'h08
`define FRD_A_DEFECTS     8'h0c
`define FRD_A_DCODE       8'h10
`define FRD_A_WADDR       8'h14
`define FRD_A_WDATA       8'h18
`define FRD_A_RMS0        8'h20
`define FRD_A_RMSN        8'h58

`define FRD_CTRL_FREC_CLR 0
`define FRD_CTRL_DIAG_CLR 1
`define FRD_CTRL_REARM    2
`define FRD_WIN_PRE_LSB   0
`define FRD_WIN_POST_LSB  16
`define FRD_WADDR_PH_LSB  16

`define FRD_CHK_CODES     15
`define FRD_COMM_CODES    5
`define FRD_COMM_FIRST    28

`endif

// ==== logic/frd_pkg.sv ====
package frd_pkg;
    typedef enum logic [1:0] {CAP_RUN, CAP_POST, CAP_HELD} frd_cap_type;
    typedef logic [31:0] frd_defect_type;
endpackage

// ==== logic/frd_diag_if.sv ====
interface frd_diag_if;
    logic                     clr;
    logic                     card;
    logic                     lock;
    logic                     run;
    logic                     alarm;
    frd_pkg::frd_defect_type  defects;
    modport diag (input clr, input card, output lock, output run, output alarm, output defects);
    modport host (output clr, output card, input lock, input run, input alarm, input defects);
endinterface

// ==== logic/frd_wave_mem.sv ====
module frd_wave_mem #(
    parameter int W     = 48,
    parameter int DEPTH = 2688,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic          clk,    // sampling clock
    input  wire logic          rstn,   // async reset of read register
    input  wire logic          we,     // write strobe
    input  wire logic [AW-1:0] waddr,  // write address
    input  wire logic [W-1:0]  wdata,  // write data
    input  wire logic [AW-1:0] raddr,  // read address
    output logic      [W-1:0]  rdata   // registered read data
);
    logic [W-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= '0;
        end else begin
            rdata <= mem[raddr];
        end
    end
endmodule

// ==== logic/frd_diag.sv ====
`include "frd_defs.svh"

module frd_diag (
    input  wire logic                        pclk,         // sampling clock
    input  wire logic                        presetn,      // power cycle reset
    input  wire logic                        retain_rstn,  // first power-up of retained store
    input  wire logic [`FRD_CHK_CODES-1:0]   chk_fail_in,  // internal check failures
    input  wire logic [`FRD_COMM_CODES-1:0]  comm_err_in,  // card check and switch errors
    input  wire logic                        cpu_fail_in,  // processor failure
    frd_diag_if.diag                         dif           // link to the top
);
    logic [20:0] s1_q;
    logic [20:0] s2_q;
    logic [`FRD_COMM_CODES-1:0] comm_v;
    logic        sev_now;
    logic        cpu_now;
    frd_pkg::frd_defect_type new_mask;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= {cpu_fail_in, comm_err_in, chk_fail_in};
            s2_q <= s1_q;
        end
    end

    assign comm_v   = s2_q[19:15] & {`FRD_COMM_CODES{dif.card}};
    assign sev_now  = (|s2_q[14:0]) | comm_v[0];
    assign cpu_now  = s2_q[20];
    assign new_mask = {comm_v, 12'h000, s2_q[14:0]};

    // active failure state is cleared only by a power cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dif.lock  <= 1'b0;
            dif.run   <= 1'b1;
            dif.alarm <= 1'b0;
        end else begin
            dif.lock  <= dif.lock | sev_now;
            dif.run   <= dif.run & ~(sev_now | cpu_now);
            dif.alarm <= dif.alarm | sev_now | cpu_now;
        end
    end

    // accumulated codes survive a power cycle; a new code wins over a clear
    always_ff @(posedge pclk or negedge retain_rstn) begin
        if (!retain_rstn) begin
            dif.defects <= '0;
        end else begin
            dif.defects <= (dif.defects & ~{32{dif.clr}}) | new_mask;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn || !retain_rstn);

    sequence s_severe;
        sev_now;
    endsequence

    a_severe_outputs: assert property (s_severe |=> dif.lock && !dif.run && dif.alarm)
        else $error("severe failure did not lock outputs and raise alarm");
    a_switch_err_soft: assert property (!sev_now && !cpu_now |=>
        $stable(dif.lock) && $stable(dif.run) && $stable(dif.alarm))
        else $error("switch error changed run, alarm or lock");
    a_cpu_no_lock: assert property (cpu_now && !dif.lock && !sev_now |=>
        !dif.lock && dif.alarm && !dif.run)
        else $error("cpu failure handling wrong");
    a_defect_keep: assert property (!dif.clr |=>
        (dif.defects & $past(dif.defects)) == $past(dif.defects))
        else $error("accumulated defect code lost without clear");
    a_card_gate: assert property (!dif.card |=> ((dif.defects & ~$past(dif.defects))
        & 32'hf8000000) == 32'h00000000)
        else $error("card code recorded with no card fitted");
endmodule

// ==== logic/frd_top.sv ====
`include "frd_defs.svh"

module frd_top #(
    parameter int RMS_W   = `FRD_RMS_W,
    parameter int CAP_PTS = `FRD_CAP_PTS
) (
    input  wire logic                        pclk,         // sampling clock, 50 MHz
    input  wire logic                        presetn,      // power cycle reset, async
    input  wire logic                        retain_rstn,  // retained store reset, async
    input  wire logic                        psel,         // apb select
    input  wire logic                        penable,      // apb enable
    input  wire logic                        pwrite,       // apb direction
    input  wire logic [7:0]                  paddr,        // apb byte address
    input  wire logic [31:0]                 pwdata,       // apb write data
    output logic      [31:0]                 prdata,       // apb read data
    output logic                             pready,       // apb ready
    output logic                             pslverr,      // apb error
    input  wire logic                        trip_in,      // protection operate pin
    input  wire logic                        aux_lost_in,  // auxiliary power lost pin
    input  wire logic                        card_in,      // communication card fitted pin
    input  wire logic [3*RMS_W-1:0]          rms_in,       // per-phase effective currents
    input  wire logic                        samp_stb,     // one pulse per 30 degrees
    input  wire logic [3*RMS_W-1:0]          samp_in,      // per-phase samples
    input  wire logic [`FRD_CHK_CODES-1:0]   chk_fail_in,  // codes 0001..0015
    input  wire logic [`FRD_COMM_CODES-1:0]  comm_err_in,  // codes 0028..0032
    input  wire logic                        cpu_fail_in,  // processor failure pin
    output logic                             prot_lock,    // protection outputs locked
    output logic                             run_led,      // run indicator lit
    output logic                             alarm_close   // alarm break contact closed
);
    localparam int PW = $clog2(CAP_PTS);
    localparam int DW = 3 * RMS_W;

    frd_diag_if dif ();

    logic [2:0]              trip_sq;
    logic [1:0]              aux_sq;
    logic [1:0]              card_sq;
    logic                    trip_rise;
    logic [DW-1:0]           hist_q [`FRD_RECORDS];
    logic [2:0]              rec_cnt_q;
    frd_pkg::frd_cap_type    cap_q;
    logic [PW-1:0]           wr_ptr_q;
    logic [PW-1:0]           trip_ptr_q;
    logic [PW-1:0]           post_left_q;
    logic [8:0]              pre_q;
    logic [8:0]              post_q;
    logic [PW-1:0]           waddr_q;
    logic [1:0]              wph_q;
    logic [PW-1:0]           win_start;
    logic [PW-1:0]           mem_raddr;
    logic [DW-1:0]           mem_rdata;
    logic                    mem_we;
    logic                    wave_ready;
    logic                    setup;
    logic                    access;
    logic                    done;
    logic                    wr_ok;
    logic                    frec_clr;
    logic                    rearm;
    logic [31:0]             rdata_c;
    logic                    err_c;

    function automatic logic [PW-1:0] ptr_add(input logic [PW-1:0] a, input logic [PW-1:0] b);
        logic [PW:0] s;
        s = {1'b0, a} + {1'b0, b};
        if (s >= (PW+1)'(CAP_PTS)) begin
            s = s - (PW+1)'(CAP_PTS);
        end
        return s[PW-1:0];
    endfunction

    function automatic logic [PW-1:0] cyc_to_pts(input logic [8:0] cyc);
        return PW'(cyc * `FRD_SPC);
    endfunction

    function automatic logic win_fits(input logic [8:0] pre, input logic [8:0] post);
        return ({1'b0, pre} + {1'b0, post}) <= 10'(`FRD_CAP_CYC);
    endfunction

    function automatic logic [15:0] code_bcd(input frd_pkg::frd_defect_type m);
        logic [5:0] c;
        c = 6'h00;
        for (int i = 31; i >= 0; i--) begin
            if (m[i]) begin
                c = 6'(i + 1);
            end
        end
        return {8'h00, 4'(c / 6'd10), 4'(c % 6'd10)};
    endfunction

    // pins cross into the clock domain through two flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trip_sq <= '0;
            aux_sq  <= '0;
            card_sq <= '0;
        end else begin
            trip_sq <= {trip_sq[1:0], trip_in};
            aux_sq  <= {aux_sq[0], aux_lost_in};
            card_sq <= {card_sq[0], card_in};
        end
    end

    assign trip_rise = trip_sq[1] & ~trip_sq[2];

    // apb: one wait state, answer on the second access cycle
    assign setup  = psel & ~penable;
    assign access = psel & penable;
    assign done   = access & pready;
    assign wr_ok  = done & pwrite & ~pslverr;
    assign frec_clr = wr_ok && paddr == `FRD_A_CTRL && pwdata[`FRD_CTRL_FREC_CLR];
    assign rearm    = wr_ok && paddr == `FRD_A_CTRL && pwdata[`FRD_CTRL_REARM];
    assign dif.clr  = wr_ok && paddr == `FRD_A_CTRL && pwdata[`FRD_CTRL_DIAG_CLR];
    assign dif.card = card_sq[1];

    // effective-current history survives a power loss
    always_ff @(posedge pclk or negedge retain_rstn) begin
        if (!retain_rstn) begin
            for (int i = 0; i < `FRD_RECORDS; i++) begin
                hist_q[i] <= '0;
            end
            rec_cnt_q <= 3'h0;
        end else if (trip_rise) begin
            hist_q[0] <= rms_in;
            for (int i = 1; i < `FRD_RECORDS; i++) begin
                hist_q[i] <= frec_clr ? '0 : hist_q[i-1];
            end
            if (frec_clr) begin
                rec_cnt_q <= 3'h1;
            end else if (rec_cnt_q < 3'(`FRD_RECORDS)) begin
                rec_cnt_q <= rec_cnt_q + 3'h1;
            end
        end else if (frec_clr) begin
            for (int i = 0; i < `FRD_RECORDS; i++) begin
                hist_q[i] <= '0;
            end
            rec_cnt_q <= 3'h0;
        end
    end

    // waveform ring: runs freely, a trip freezes it after the post-trip span
    assign mem_we = samp_stb && cap_q != frd_pkg::CAP_HELD;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_q       <= frd_pkg::CAP_RUN;
            wr_ptr_q    <= '0;
            trip_ptr_q  <= '0;
            post_left_q <= '0;
        end else begin
            if (mem_we) begin
                wr_ptr_q <= ptr_add(wr_ptr_q, PW'(1));
            end
            if (aux_sq[1] || frec_clr) begin
                cap_q <= frd_pkg::CAP_RUN;
            end else begin
                case (cap_q)
                    frd_pkg::CAP_RUN: begin
                        if (trip_rise) begin
                            trip_ptr_q  <= wr_ptr_q;
                            post_left_q <= cyc_to_pts(post_q);
                            cap_q <= (post_q == 9'h000) ? frd_pkg::CAP_HELD : frd_pkg::CAP_POST;
                        end
                    end
                    frd_pkg::CAP_POST: begin
                        if (samp_stb) begin
                            post_left_q <= post_left_q - PW'(1);
                            if (post_left_q == PW'(1)) begin
                                cap_q <= frd_pkg::CAP_HELD;
                            end
                        end
                    end
                    frd_pkg::CAP_HELD: begin
                        if (rearm) begin
                            cap_q <= frd_pkg::CAP_RUN;
                        end
                    end
                    default: begin
                        cap_q <= frd_pkg::CAP_RUN;
                    end
                endcase
            end
        end
    end

    assign wave_ready = cap_q == frd_pkg::CAP_HELD;
    assign win_start  = ptr_add(trip_ptr_q, PW'(CAP_PTS) - cyc_to_pts(pre_q));
    assign mem_raddr  = ptr_add(win_start, waddr_q);

    frd_wave_mem #(
        .W     (DW),
        .DEPTH (CAP_PTS),
        .AW    (PW)
    ) u_mem (
        .clk   (pclk),
        .rstn  (presetn),
        .we    (mem_we),
        .waddr (wr_ptr_q),
        .wdata (samp_in),
        .raddr (mem_raddr),
        .rdata (mem_rdata)
    );

    frd_diag u_diag (
        .pclk        (pclk),
        .presetn     (presetn),
        .retain_rstn (retain_rstn),
        .chk_fail_in (chk_fail_in),
        .comm_err_in (comm_err_in),
        .cpu_fail_in (cpu_fail_in),
        .dif         (dif.diag)
    );

    always_comb begin
        int ix;
        ix      = int'(paddr[7:2]) - int'(`FRD_A_RMS0 >> 2);
        rdata_c = 32'h00000000;
        err_c   = 1'b0;
        case (paddr)
            `FRD_A_CTRL:    rdata_c = 32'h00000000;
            `FRD_A_WIN: begin
                rdata_c = {7'h00, post_q, 7'h00, pre_q};
                err_c   = pwrite && !win_fits(pwdata[24:16], pwdata[8:0]);
            end
            `FRD_A_STATUS:  rdata_c = {21'h000000, alarm_close, run_led, prot_lock, 2'h0,
                                       card_sq[1], wave_ready, 1'b0, rec_cnt_q};
            `FRD_A_DEFECTS: rdata_c = dif.defects;
            `FRD_A_DCODE:   rdata_c = {16'h0000, code_bcd(dif.defects)};
            `FRD_A_WADDR:   rdata_c = {14'h0000, wph_q, {(16-PW){1'b0}}, waddr_q};
            `FRD_A_WDATA: begin
                err_c = pwrite || !card_sq[1] || !wave_ready || wph_q == 2'h3;
                if (!err_c) begin
                    rdata_c = {16'h0000, mem_rdata[wph_q*RMS_W +: RMS_W]};
                end
            end
            default: begin
                if (paddr >= `FRD_A_RMS0 && paddr <= `FRD_A_RMSN && paddr[1:0] == 2'h0
                    && !pwrite) begin
                    rdata_c = 32'(hist_q[ix / 3][(ix % 3) * RMS_W +: RMS_W]);
                end else begin
                    err_c = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready <= access & ~pready;
            if (access && !pready) begin
                pslverr <= err_c;
                prdata  <= pwrite ? 32'h00000000 : rdata_c;
            end else if (done) begin
                pslverr <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q   <= `FRD_PRE_RST;
            post_q  <= `FRD_POST_RST;
            waddr_q <= '0;
            wph_q   <= 2'h0;
        end else if (wr_ok && paddr == `FRD_A_WIN) begin
            pre_q  <= pwdata[`FRD_WIN_PRE_LSB +: 9];
            post_q <= pwdata[`FRD_WIN_POST_LSB +: 9];
        end else if (wr_ok && paddr == `FRD_A_WADDR) begin
            waddr_q <= pwdata[PW-1:0];
            wph_q   <= pwdata[`FRD_WADDR_PH_LSB +: 2];
        end
    end

    assign prot_lock   = dif.lock;
    assign run_led     = dif.run;
    assign alarm_close = dif.alarm;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn || !retain_rstn);

    sequence s_clean_trip;
        trip_rise && !frec_clr;
    endsequence

    a_trip_capture: assert property (s_clean_trip |=> hist_q[0] == $past(rms_in))
        else $error("trip did not capture effective currents");
    a_hist_shift: assert property (s_clean_trip |=> hist_q[4] == $past(hist_q[3]))
        else $error("history did not shift down");
    a_rec_count: assert property (s_clean_trip |=>
        rec_cnt_q == ($past(rec_cnt_q) == 3'h5 ? 3'h5 : $past(rec_cnt_q) + 3'h1))
        else $error("record count wrong");
    a_aux_keep: assert property (aux_sq[1] && !trip_rise && !frec_clr |=>
        !wave_ready && hist_q[0] == $past(hist_q[0]))
        else $error("power loss handling wrong");
    a_frec_clear: assert property (frec_clr && !trip_rise |=> rec_cnt_q == 3'h0
        && hist_q[0] == '0 && !wave_ready)
        else $error("fault record reset incomplete");
    a_wave_card: assert property (access && !pready && paddr == `FRD_A_WDATA
        && !card_sq[1] |=> pready && pslverr)
        else $error("waveform read allowed without card");
    a_post_span: assert property (cap_q == frd_pkg::CAP_RUN && trip_rise && !aux_sq[1]
        && !frec_clr && post_q != 9'h000 |=> cap_q == frd_pkg::CAP_POST
        && post_left_q == cyc_to_pts($past(post_q)))
        else $error("post-trip span not armed");
    a_win_limit: assert property (win_fits(pre_q, post_q))
        else $error("window exceeds capacity");
    a_ring_runs: assert property (samp_stb && cap_q == frd_pkg::CAP_RUN |=>
        wr_ptr_q != $past(wr_ptr_q))
        else $error("ring stalled while running");
    a_apb_wait: assert property (setup |=> !pready ##1 pready)
        else $error("apb answer timing wrong");
endmodule

// ==== sim/frd_src_model.sv ====
module frd_src_model #(
    parameter int GAP = 4
) (
    input  wire logic        pclk,     // sampling clock
    input  wire logic        presetn,  // power cycle reset
    output logic             samp_stb, // one pulse per sample slot
    output logic [47:0]      samp_in   // same ramp on every phase
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0]  gap_q;
    logic [15:0] val_q;
    // ramp steps once per strobe so a lost or doubled sample shows in the record
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_q <= 8'h00;
            val_q <= 16'h0000;
        end else if (gap_q == 8'(GAP - 1)) begin
            gap_q <= 8'h00;
            val_q <= val_q + 16'h0001;
        end else begin
            gap_q <= gap_q + 8'h01;
        end
    end
    assign samp_stb = (gap_q == 8'(GAP - 1));
    assign samp_in  = {3{val_q}};
endmodule

// ==== sim/tb_fault_record_self_diagnosis.sv ====
`include "frd_defs.svh"

module tb_fault_record_self_diagnosis;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk, presetn, retain_rstn, psel, penable, pwrite, trip_in;
    logic        aux_lost_in, card_in, samp_stb, cpu_fail_in, prot_lock;
    logic        run_led, alarm_close, pready, pslverr, er;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [47:0] rms_in, samp_in, v;
    logic [14:0] chk_fail_in;
    logic [4:0]  comm_err_in;
    logic [15:0] d0;
    logic [47:0] hist[$];
    int          error_cnt = 0;
    int          cmp_count = 0;
    int          seed = 32'hbb96e52d;

    frd_top u_frd_top (.pclk(pclk), .presetn(presetn), .retain_rstn(retain_rstn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .trip_in(trip_in),
        .aux_lost_in(aux_lost_in), .card_in(card_in), .rms_in(rms_in), .samp_stb(samp_stb),
        .samp_in(samp_in), .chk_fail_in(chk_fail_in), .comm_err_in(comm_err_in),
        .cpu_fail_in(cpu_fail_in), .prot_lock(prot_lock), .run_led(run_led),
        .alarm_close(alarm_close));
    frd_src_model u_frd_src_model (.pclk(pclk), .presetn(presetn), .samp_stb(samp_stb),
        .samp_in(samp_in));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s exp %h got %h", n, e, g);
        end
    endtask

    function automatic logic [31:0] bcd_exp(input int c);
        return 32'(c / 10 * 16 + c % 10);
    endfunction

    task conclude();
        $display("checks %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (int i = 0; i < 20 && pready !== 1'b1; i++) begin
            @(posedge pclk);
        end
        if (pready !== 1'b1) begin
            chk("pready", 32'h1, 32'h0);
            conclude();
        end else begin
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, e, rd);
    endtask

    task outs(input logic [2:0] e);
        repeat (6) @(posedge pclk);
        chk("alarm run lock", {29'h0, e}, {29'h0, alarm_close, run_led, prot_lock});
    endtask

    task trip();
        trip_in <= 1'b1;
        repeat (5) @(posedge pclk);
        trip_in <= 1'b0;
        repeat (5) @(posedge pclk);
    endtask

    // trip pin is held low by the bench before every power cycle
    task pwr_cycle();
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
    endtask

    task chk_hist();
        for (int r = 0; r < 5; r++) begin
            for (int p = 0; p < 3; p++) begin
                rd_chk("rms", 8'(8'h20 + 4 * (3 * r + p)), {16'h0, hist[r][16*p+:16]});
            end
        end
    endtask

    initial begin
        {presetn, retain_rstn, psel, penable, pwrite, trip_in, aux_lost_in} = 7'h0;
        {card_in, cpu_fail_in, chk_fail_in, comm_err_in, paddr, pwdata} = '0;
        rms_in = 48'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        retain_rstn <= 1'b1;
        repeat (2) @(posedge pclk);
        apb(1'b0, `FRD_A_STATUS, 32'h0);
        chk("status", 32'h0200, rd & 32'h0737);
        rd_chk("win", `FRD_A_WIN, 32'h00700070);
        for (int i = 0; i < 6; i++) begin
            v = 48'({$random(seed), $random(seed)});
            rms_in <= v;
            hist.push_front(v);
            trip();
        end
        apb(1'b0, `FRD_A_STATUS, 32'h0);
        chk("count", 32'h5, {29'h0, rd[2:0]});
        chk_hist();
        pwr_cycle();
        chk_hist();
        $display("test history done");
        card_in <= 1'b1;
        apb(1'b1, `FRD_A_WIN, 32'h00010001);
        trip();
        rd = 32'h0;
        for (int i = 0; i < 40 && rd[4] !== 1'b1; i++) begin
            apb(1'b0, `FRD_A_STATUS, 32'h0);
        end
        chk("frozen", 32'h10, rd & 32'h10);
        apb(1'b1, `FRD_A_WADDR, 32'h0);
        apb(1'b0, `FRD_A_WDATA, 32'h0);
        chk("wdata err", 32'h0, {31'h0, er});
        d0 = rd[15:0];
        apb(1'b1, `FRD_A_WADDR, 32'd23);
        apb(1'b0, `FRD_A_WDATA, 32'h0);
        chk("span", {16'h0, d0 + 16'd23}, {16'h0, rd[15:0]});
        card_in <= 1'b0;
        repeat (4) @(posedge pclk);
        apb(1'b0, `FRD_A_WDATA, 32'h0);
        chk("nocard err", 32'h1, {31'h0, er});
        aux_lost_in <= 1'b1;
        repeat (5) @(posedge pclk);
        aux_lost_in <= 1'b0;
        apb(1'b0, `FRD_A_STATUS, 32'h0);
        chk("aux", 32'h5, rd & 32'h17);
        apb(1'b1, `FRD_A_WIN, 32'h001900c8);
        chk("win err", 32'h1, {31'h0, er});
        rd_chk("win", `FRD_A_WIN, 32'h00010001);
        apb(1'b1, `FRD_A_WIN, 32'h000000e0);
        chk("win edge", 32'h0, {31'h0, er});
        trip();
        apb(1'b0, `FRD_A_STATUS, 32'h0);
        chk("post zero", 32'h10, rd & 32'h10);
        apb(1'b1, `FRD_A_CTRL, 32'h4);
        apb(1'b0, `FRD_A_STATUS, 32'h0);
        chk("rearm", 32'h0, rd & 32'h10);
        apb(1'b0, 8'h1c, 32'h0);
        chk("unmapped", 32'h1, {31'h0, er});
        apb(1'b1, `FRD_A_CTRL, 32'h1);
        rd_chk("rms clr", 8'h20, 32'h0);
        apb(1'b0, `FRD_A_STATUS, 32'h0);
        chk("count clr", 32'h0, {29'h0, rd[2:0]});
        $display("test waveform done");
        // descending, so the lowest accumulated code is always the newest one
        for (int k = 14; k >= 0; k--) begin
            chk_fail_in <= 15'(1 << k);
            outs(3'b101);
            rd_chk("code", `FRD_A_DCODE, bcd_exp(k + 1));
            chk_fail_in <= 15'h0;
            pwr_cycle();
            outs(3'b010);
        end
        rd_chk("defects", `FRD_A_DEFECTS, 32'h7fff);
        apb(1'b1, `FRD_A_CTRL, 32'h2);
        rd_chk("diag clr", `FRD_A_DEFECTS, 32'h0);
        comm_err_in <= 5'h1f;
        outs(3'b010);
        rd_chk("nocard", `FRD_A_DEFECTS, 32'h0);
        card_in <= 1'b1;
        comm_err_in <= 5'h1e;
        outs(3'b010);
        rd_chk("switch", `FRD_A_DEFECTS, 32'hf0000000);
        comm_err_in <= 5'h1f;
        outs(3'b101);
        rd_chk("card", `FRD_A_DEFECTS, 32'hf8000000);
        comm_err_in <= 5'h0;
        pwr_cycle();
        cpu_fail_in <= 1'b1;
        outs(3'b100);
        $display("test diagnosis done");
        conclude();
    end

    initial begin
        repeat (100000) @(posedge pclk);
        chk("timeout", 32'h0, 32'h1);
        conclude();
    end
endmodule
